/* File: spk_servo_consts.vh */
// Purpose: Shared constants for the speaker output and servo register bank
// Assumes: Included by bare name from the slave port, the register bank and the bench
// Notes:   Definitions only
`ifndef SPK_SERVO_CONSTS_VH
`define SPK_SERVO_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_SPK_LEFT_LEVEL    8'h3e
`define IDX_SPK_RIGHT_LEVEL   8'h3f
`define IDX_SPK_OUTPUT_CTL    8'h41
`define IDX_SERVO_ENABLE      8'h43
`define IDX_SERVO_MODE        8'h45
`define IDX_SERVO_LEFT_OFS    8'h47
`define IDX_SERVO_RIGHT_OFS   8'h48

// Speaker channel register fields
`define BIT_SILENCE           8
`define BIT_LEVEL_APPLY       7
`define BIT_CROSSING_GATE     6
`define LEVEL_MSB             5
`define RST_SILENCE           1'h1
`define RST_CROSSING_GATE     1'h0
`define RST_SPK_LEVEL         6'h39

// Speaker output control fields
`define BIT_DISCHARGE         1
`define BIT_TIE_SELECT        0
`define RST_DISCHARGE         1'h0
`define RST_TIE_SELECT        1'h0

// Servo enable control fields
`define BIT_SERVO_MASTER      4
`define SERVO_ENA_MSB         3
`define RST_SERVO_MASTER      1'h1
`define RST_SERVO_ENA         4'h0

// Servo mode codes
`define SERVO_MODE_WRITE_STOP    2'h0
`define SERVO_MODE_WRITE_UPDATE  2'h1
`define SERVO_MODE_START_STOP    2'h2
`define SERVO_MODE_START_UPDATE  2'h3
`define RST_SERVO_MODE           2'h0
`define RST_SERVO_WRITE_MODE     1'h1

// Offset value reset
`define RST_SERVO_OFS         8'h00

// AXI responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

/* File: axi_lite_slave_port.v */
// Purpose: AXI4-Lite slave front end turning bus beats into single-cycle strobes
// Assumes: One write and one read in flight at most
// Notes:   Write response fixed at three cycles, read response at two cycles, after the last beat is taken
`default_nettype none
`timescale 1ns/100ps
`include "spk_servo_consts.vh"

module axi_lite_slave_port #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  output reg               wr_stb,
  output reg  [ADDR_W-1:0] wr_addr,
  output reg  [31:0]       wr_data,
  output reg  [3:0]        wr_strb,
  input  wire              wr_ok,
  output reg               rd_stb,
  output reg  [ADDR_W-1:0] rd_addr,
  input  wire [31:0]       rd_data,
  input  wire              rd_ok
);

  reg aw_held;
  reg w_held;
  reg wr_wait;
  reg rd_wait;

  // ****************************************************
  // Write channel: address and data may arrive in either order
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_wait <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else begin
      wr_stb  <= 1'b0;
      awready <= !aw_held && !awready && !bvalid && !wr_wait && awvalid;
      wready  <= !w_held && !wready && !bvalid && !wr_wait && wvalid;
      if (awready && awvalid) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wready && wvalid) begin
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        wr_stb  <= 1'b1;
        wr_wait <= 1'b1;
      end
      if (wr_stb) begin
        wr_wait <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Read channel
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rd_stb  <= 1'b0;
      rd_wait <= 1'b0;
      rd_addr <= {ADDR_W{1'b0}};
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      rd_stb  <= 1'b0;
      arready <= !arready && !rvalid && !rd_wait && !rd_stb && arvalid;
      if (arready && arvalid) begin
        rd_addr <= araddr;
        rd_stb  <= 1'b1;
        rd_wait <= 1'b1;
      end
      if (rd_stb) begin
        rd_wait <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule // axi_lite_slave_port
`default_nettype wire

/* File: crossing_level_ramp.v */
// Purpose: Moves an applied speaker level to its output, gated on a crossing
// Assumes: Crossing pulse comes from the analogue path, synchronous to clk
// Notes:   With the gate off the target passes at once
`default_nettype none
`timescale 1ns/100ps

module crossing_level_ramp #(
  parameter LEVEL_W = 6,
  parameter [LEVEL_W-1:0] RST_LEVEL = 6'h39
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               gate_on,
  input  wire               crossing,
  input  wire [LEVEL_W-1:0] target,
  output reg  [LEVEL_W-1:0] level
);

  // ****************************************************
  // Hold the old gain until the waveform crosses zero, to avoid clicks
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RST_LEVEL;
    end else if (level != target && (!gate_on || crossing)) begin
      level <= target;
    end
  end

endmodule // crossing_level_ramp
`default_nettype wire

/* File: spk_out_dc_servo_regs.v */
// Purpose: Speaker output and DC servo control register bank on AXI4-Lite
// Assumes: Single clock; crossing pulses synchronous to SYS_CLK_IN
// Notes:   Register byte address is four times the register index
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
`timescale 1ns/100ps
`include "spk_servo_consts.vh"

// Function
// - Speaker mute bit 8, resets muted
// - Bit 7 write applies both levels together
// - Bit 6 enables zero-cross gating, resets off
// - Level code 0 is -57dB, 1dB steps
// - Both levels reset to 0dB code
// - Control bit 1 enables discharge, resets off
// - Control bit 0 picks tie resistance
// - Servo master bit 4, resets enabled
// - Four per-output servo enables, reset zero
// - Two-bit servo mode, resets write-stop
// - Signed offsets sent in write modes
// - Offset registers reset to zero
module spk_out_dc_servo_regs #(
  parameter ADDR_W = 12
) (
  input  wire              SYS_CLK_IN,
  input  wire              RESETN_IN,
  input  wire [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire              S_AXI_AWVALID_IN,
  output wire              S_AXI_AWREADY_OUT,
  input  wire [31:0]       S_AXI_WDATA_IN,
  input  wire [3:0]        S_AXI_WSTRB_IN,
  input  wire              S_AXI_WVALID_IN,
  output wire              S_AXI_WREADY_OUT,
  output wire [1:0]        S_AXI_BRESP_OUT,
  output wire              S_AXI_BVALID_OUT,
  input  wire              S_AXI_BREADY_IN,
  input  wire [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire              S_AXI_ARVALID_IN,
  output wire              S_AXI_ARREADY_OUT,
  output wire [31:0]       S_AXI_RDATA_OUT,
  output wire [1:0]        S_AXI_RRESP_OUT,
  output wire              S_AXI_RVALID_OUT,
  input  wire              S_AXI_RREADY_IN,
  input  wire              LEFT_CROSSING_IN,
  input  wire              RIGHT_CROSSING_IN,
  output reg               LEFT_SPEAKER_SILENCE_OUT,
  output reg               RIGHT_SPEAKER_SILENCE_OUT,
  output wire [5:0]        LEFT_SPEAKER_LEVEL_OUT,
  output wire [5:0]        RIGHT_SPEAKER_LEVEL_OUT,
  output reg               SPEAKER_DISCHARGE_OUT,
  output reg               TIE_RESISTANCE_SELECT_OUT,
  output reg               SERVO_MASTER_ENABLE_OUT,
  output reg  [3:0]        SERVO_OUTPUT_ENABLES_OUT,
  output reg  [1:0]        SERVO_MODE_OUT,
  output reg               SERVO_WRITE_MODE_OUT,
  output reg  [7:0]        LEFT_PHONES_OFFSET_OUT,
  output reg  [7:0]        RIGHT_PHONES_OFFSET_OUT
);

  // ****************************************************
  // Reset release
  // ****************************************************
  reg rst_meta;
  reg rst_n;

  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************
  // Bus front end
  // ****************************************************
  wire              wr_stb;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;
  wire              rd_stb;
  wire [ADDR_W-1:0] rd_addr;
  reg  [31:0]       rd_data;
  reg               rd_ok;
  reg               wr_ok;

  axi_lite_slave_port #(.ADDR_W(ADDR_W)) bus (
    .clk     (SYS_CLK_IN),
    .rst_n   (rst_n),
    .awaddr  (S_AXI_AWADDR_IN),
    .awvalid (S_AXI_AWVALID_IN),
    .awready (S_AXI_AWREADY_OUT),
    .wdata   (S_AXI_WDATA_IN),
    .wstrb   (S_AXI_WSTRB_IN),
    .wvalid  (S_AXI_WVALID_IN),
    .wready  (S_AXI_WREADY_OUT),
    .bresp   (S_AXI_BRESP_OUT),
    .bvalid  (S_AXI_BVALID_OUT),
    .bready  (S_AXI_BREADY_IN),
    .araddr  (S_AXI_ARADDR_IN),
    .arvalid (S_AXI_ARVALID_IN),
    .arready (S_AXI_ARREADY_OUT),
    .rdata   (S_AXI_RDATA_OUT),
    .rresp   (S_AXI_RRESP_OUT),
    .rvalid  (S_AXI_RVALID_OUT),
    .rready  (S_AXI_RREADY_IN),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_stb  (rd_stb),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ****************************************************
  // Address decode
  // ****************************************************
  wire [ADDR_W-3:0] wr_idx = wr_addr[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_idx = rd_addr[ADDR_W-1:2];
  wire              lo_en  = wr_strb[0];
  wire              hi_en  = wr_strb[1];

  reg wr_left;
  reg wr_right;
  reg wr_ctl;
  reg wr_ena;
  reg wr_mode;
  reg wr_lofs;
  reg wr_rofs;

  always @* begin
    wr_left  = 1'b0;
    wr_right = 1'b0;
    wr_ctl   = 1'b0;
    wr_ena   = 1'b0;
    wr_mode  = 1'b0;
    wr_lofs  = 1'b0;
    wr_rofs  = 1'b0;
    wr_ok    = 1'b1;
    if (wr_idx == `IDX_SPK_LEFT_LEVEL)
      wr_left = wr_stb;
    else if (wr_idx == `IDX_SPK_RIGHT_LEVEL)
      wr_right = wr_stb;
    else if (wr_idx == `IDX_SPK_OUTPUT_CTL)
      wr_ctl = wr_stb;
    else if (wr_idx == `IDX_SERVO_ENABLE)
      wr_ena = wr_stb;
    else if (wr_idx == `IDX_SERVO_MODE)
      wr_mode = wr_stb;
    else if (wr_idx == `IDX_SERVO_LEFT_OFS)
      wr_lofs = wr_stb;
    else if (wr_idx == `IDX_SERVO_RIGHT_OFS)
      wr_rofs = wr_stb;
    else
      wr_ok = 1'b0;
  end

  // ****************************************************
  // Speaker channel registers
  // ****************************************************
  reg  [5:0] left_pending;
  reg  [5:0] right_pending;
  reg  [5:0] left_target;
  reg  [5:0] right_target;
  reg        left_speaker_crossing_gate;
  reg        right_speaker_crossing_gate;
  wire       speaker_level_apply = (wr_left || wr_right) && lo_en &&
                                   wr_data[`BIT_LEVEL_APPLY];

  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      LEFT_SPEAKER_SILENCE_OUT    <= `RST_SILENCE;
      RIGHT_SPEAKER_SILENCE_OUT   <= `RST_SILENCE;
      left_speaker_crossing_gate  <= `RST_CROSSING_GATE;
      right_speaker_crossing_gate <= `RST_CROSSING_GATE;
      left_pending                <= `RST_SPK_LEVEL;
      right_pending               <= `RST_SPK_LEVEL;
      left_target                 <= `RST_SPK_LEVEL;
      right_target                <= `RST_SPK_LEVEL;
    end else begin
      if (wr_left && hi_en)
        LEFT_SPEAKER_SILENCE_OUT <= wr_data[`BIT_SILENCE];
      if (wr_right && hi_en)
        RIGHT_SPEAKER_SILENCE_OUT <= wr_data[`BIT_SILENCE];
      if (wr_left && lo_en) begin
        left_speaker_crossing_gate <= wr_data[`BIT_CROSSING_GATE];
        left_pending <= wr_data[`LEVEL_MSB:0];
      end
      if (wr_right && lo_en) begin
        right_speaker_crossing_gate <= wr_data[`BIT_CROSSING_GATE];
        right_pending <= wr_data[`LEVEL_MSB:0];
      end
      // Staged values move together so the stereo image never skews while both crossing gates are off
      if (speaker_level_apply) begin
        left_target  <= wr_left ? wr_data[`LEVEL_MSB:0] : left_pending;
        right_target <= wr_right ? wr_data[`LEVEL_MSB:0] : right_pending;
      end
    end
  end

  crossing_level_ramp #(.LEVEL_W(6), .RST_LEVEL(`RST_SPK_LEVEL)) left_ramp (
    .clk      (SYS_CLK_IN),
    .rst_n    (rst_n),
    .gate_on  (left_speaker_crossing_gate),
    .crossing (LEFT_CROSSING_IN),
    .target   (left_target),
    .level    (LEFT_SPEAKER_LEVEL_OUT)
  );

  crossing_level_ramp #(.LEVEL_W(6), .RST_LEVEL(`RST_SPK_LEVEL)) right_ramp (
    .clk      (SYS_CLK_IN),
    .rst_n    (rst_n),
    .gate_on  (right_speaker_crossing_gate),
    .crossing (RIGHT_CROSSING_IN),
    .target   (right_target),
    .level    (RIGHT_SPEAKER_LEVEL_OUT)
  );

  // ****************************************************
  // Output control and servo registers
  // ****************************************************
  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      SPEAKER_DISCHARGE_OUT     <= `RST_DISCHARGE;
      TIE_RESISTANCE_SELECT_OUT <= `RST_TIE_SELECT;
      SERVO_MASTER_ENABLE_OUT   <= `RST_SERVO_MASTER;
      SERVO_OUTPUT_ENABLES_OUT  <= `RST_SERVO_ENA;
      SERVO_MODE_OUT            <= `RST_SERVO_MODE;
      SERVO_WRITE_MODE_OUT      <= `RST_SERVO_WRITE_MODE;
      LEFT_PHONES_OFFSET_OUT    <= `RST_SERVO_OFS;
      RIGHT_PHONES_OFFSET_OUT   <= `RST_SERVO_OFS;
    end else begin
      if (wr_ctl && lo_en) begin
        SPEAKER_DISCHARGE_OUT     <= wr_data[`BIT_DISCHARGE];
        TIE_RESISTANCE_SELECT_OUT <= wr_data[`BIT_TIE_SELECT];
      end
      if (wr_ena && lo_en) begin
        SERVO_MASTER_ENABLE_OUT  <= wr_data[`BIT_SERVO_MASTER];
        SERVO_OUTPUT_ENABLES_OUT <= wr_data[`SERVO_ENA_MSB:0];
      end
      if (wr_mode && lo_en) begin
        SERVO_MODE_OUT <= wr_data[1:0];
        // Write modes are the two codes with the upper bit clear
        SERVO_WRITE_MODE_OUT <= (wr_data[1:0] == `SERVO_MODE_WRITE_STOP) ||
                                (wr_data[1:0] == `SERVO_MODE_WRITE_UPDATE);
      end
      if (wr_lofs && lo_en)
        LEFT_PHONES_OFFSET_OUT <= wr_data[7:0];
      if (wr_rofs && lo_en)
        RIGHT_PHONES_OFFSET_OUT <= wr_data[7:0];
    end
  end

  // ****************************************************
  // Read mux; update bit reads back as zero
  // ****************************************************
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (rd_idx == `IDX_SPK_LEFT_LEVEL)
      rd_data = {23'h000000, LEFT_SPEAKER_SILENCE_OUT, 1'b0,
                 left_speaker_crossing_gate, left_pending};
    else if (rd_idx == `IDX_SPK_RIGHT_LEVEL)
      rd_data = {23'h000000, RIGHT_SPEAKER_SILENCE_OUT, 1'b0,
                 right_speaker_crossing_gate, right_pending};
    else if (rd_idx == `IDX_SPK_OUTPUT_CTL)
      rd_data = {30'h00000000, SPEAKER_DISCHARGE_OUT, TIE_RESISTANCE_SELECT_OUT};
    else if (rd_idx == `IDX_SERVO_ENABLE)
      rd_data = {27'h0000000, SERVO_MASTER_ENABLE_OUT, SERVO_OUTPUT_ENABLES_OUT};
    else if (rd_idx == `IDX_SERVO_MODE)
      rd_data = {30'h00000000, SERVO_MODE_OUT};
    else if (rd_idx == `IDX_SERVO_LEFT_OFS)
      rd_data = {24'h000000, LEFT_PHONES_OFFSET_OUT};
    else if (rd_idx == `IDX_SERVO_RIGHT_OFS)
      rd_data = {24'h000000, RIGHT_PHONES_OFFSET_OUT};
    else
      rd_ok = 1'b0;
  end

endmodule // spk_out_dc_servo_regs
`default_nettype wire

/* File: spk_servo_checker.sv */
// Purpose: Bus timing and field update checks for the speaker and servo bank
// Assumes: Bound to the top module; one clock domain
// Notes:   Latencies are those the bank's slave port fixes
`default_nettype none
`timescale 1ns/100ps

module spk_servo_checker (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic        S_AXI_WVALID_IN,
  input wire logic        S_AXI_WREADY_OUT,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0]  S_AXI_RRESP_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic        LEFT_CROSSING_IN,
  input wire logic        LEFT_SPEAKER_SILENCE_OUT,
  input wire logic        RIGHT_SPEAKER_SILENCE_OUT,
  input wire logic [5:0]  LEFT_SPEAKER_LEVEL_OUT,
  input wire logic [5:0]  RIGHT_SPEAKER_LEVEL_OUT,
  input wire logic        SERVO_MASTER_ENABLE_OUT,
  input wire logic [3:0]  SERVO_OUTPUT_ENABLES_OUT,
  input wire logic [1:0]  SERVO_MODE_OUT,
  input wire logic        SERVO_WRITE_MODE_OUT,
  input wire logic [7:0]  LEFT_PHONES_OFFSET_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_bresp_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
    |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
  chk_rdata_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
  chk_write_latency: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
    && S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##3 S_AXI_BVALID_OUT)
    else $error("write answer late");
  chk_read_latency: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
    |-> ##2 S_AXI_RVALID_OUT) else $error("read answer late");
  chk_refused_zero: assert property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h2
    |-> S_AXI_RDATA_OUT == 32'h0) else $error("refused read carries data");
  chk_reset_state:
    assert property ($rose(RESETN_IN) |-> LEFT_SPEAKER_SILENCE_OUT && RIGHT_SPEAKER_SILENCE_OUT
      && LEFT_SPEAKER_LEVEL_OUT == 6'h39 && RIGHT_SPEAKER_LEVEL_OUT == 6'h39
      && SERVO_MASTER_ENABLE_OUT && SERVO_OUTPUT_ENABLES_OUT == 4'h0
      && SERVO_MODE_OUT == 2'h0 && LEFT_PHONES_OFFSET_OUT == 8'h00)
    else $error("reset state wrong");
  chk_write_flag:
    assert property (SERVO_WRITE_MODE_OUT == !SERVO_MODE_OUT[1])
    else $error("write mode flag wrong");
  chk_fields_on_write:
    assert property ($changed({LEFT_SPEAKER_SILENCE_OUT, RIGHT_SPEAKER_SILENCE_OUT,
      SERVO_MASTER_ENABLE_OUT, SERVO_OUTPUT_ENABLES_OUT, SERVO_MODE_OUT})
      |-> ##[0:1] S_AXI_BVALID_OUT) else $error("field moved without a write");
  chk_level_cause:
    assert property ($changed(LEFT_SPEAKER_LEVEL_OUT) |-> $past(LEFT_CROSSING_IN)
      || S_AXI_BVALID_OUT || $past(S_AXI_BVALID_OUT)) else $error("level moved alone");
endmodule // spk_servo_checker

bind spk_out_dc_servo_regs spk_servo_checker chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN),
  .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
  .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
  .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
  .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
  .S_AXI_RREADY_IN(S_AXI_RREADY_IN), .LEFT_CROSSING_IN(LEFT_CROSSING_IN),
  .LEFT_SPEAKER_SILENCE_OUT(LEFT_SPEAKER_SILENCE_OUT),
  .RIGHT_SPEAKER_SILENCE_OUT(RIGHT_SPEAKER_SILENCE_OUT),
  .LEFT_SPEAKER_LEVEL_OUT(LEFT_SPEAKER_LEVEL_OUT),
  .RIGHT_SPEAKER_LEVEL_OUT(RIGHT_SPEAKER_LEVEL_OUT),
  .SERVO_MASTER_ENABLE_OUT(SERVO_MASTER_ENABLE_OUT),
  .SERVO_OUTPUT_ENABLES_OUT(SERVO_OUTPUT_ENABLES_OUT),
  .SERVO_MODE_OUT(SERVO_MODE_OUT), .SERVO_WRITE_MODE_OUT(SERVO_WRITE_MODE_OUT),
  .LEFT_PHONES_OFFSET_OUT(LEFT_PHONES_OFFSET_OUT)
);
`default_nettype wire

/* File: spk_out_dc_servo_regs_tb_top.sv */
// Purpose: Self-checking bench for the speaker and servo register bank
// Assumes: AXI4-Lite master drives on rising edges; fixed seed
// Notes:   Byte address is four times the register index
`default_nettype none
`timescale 1ns/100ps
`include "spk_servo_consts.vh"

module spk_out_dc_servo_regs_tb_top;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, lx, rx;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd, d;
  logic [3:0]  wstrb;
  logic [1:0]  rsp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         lsil, rsil, dis, tie, mst, wmode;
  wire  [1:0]  bresp, rresp, mode;
  wire  [31:0] rdata;
  wire  [5:0]  llev, rlev;
  wire  [3:0]  sena;
  wire  [7:0]  lofs, rofs;
  int          miscompares, samples_checked, i, k, seed;
  logic [7:0]  idx [7] = '{`IDX_SPK_LEFT_LEVEL, `IDX_SPK_RIGHT_LEVEL, `IDX_SPK_OUTPUT_CTL,
    `IDX_SERVO_ENABLE, `IDX_SERVO_MODE, `IDX_SERVO_LEFT_OFS, `IDX_SERVO_RIGHT_OFS};
  logic [31:0] rstv [7] = '{32'h139, 32'h139, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0};
  logic [31:0] msk [7] = '{32'h17f, 32'h17f, 32'h3, 32'h1f, 32'h3, 32'hff, 32'hff};

  spk_out_dc_servo_regs #(.ADDR_W(12)) DUT (
    .SYS_CLK_IN(clk), .RESETN_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .LEFT_CROSSING_IN(lx), .RIGHT_CROSSING_IN(rx),
    .LEFT_SPEAKER_SILENCE_OUT(lsil), .RIGHT_SPEAKER_SILENCE_OUT(rsil),
    .LEFT_SPEAKER_LEVEL_OUT(llev), .RIGHT_SPEAKER_LEVEL_OUT(rlev),
    .SPEAKER_DISCHARGE_OUT(dis), .TIE_RESISTANCE_SELECT_OUT(tie),
    .SERVO_MASTER_ENABLE_OUT(mst), .SERVO_OUTPUT_ENABLES_OUT(sena),
    .SERVO_MODE_OUT(mode), .SERVO_WRITE_MODE_OUT(wmode),
    .LEFT_PHONES_OFFSET_OUT(lofs), .RIGHT_PHONES_OFFSET_OUT(rofs)
  );

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Counts: checked=%0d mismatched=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ready rises only once the answer shows, so the hold checks see a stall
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awaddr <= {2'b00, a, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(bvalid && bready); n++) begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && !bready)
        bready <= 1'b1;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (n == 50) begin
      check(32'h0, 32'h1);
      results();
    end
  endtask

  task automatic rdreg(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= {2'b00, a, 2'b00};
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !(rvalid && rready); n++) begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && !rready)
        rready <= 1'b1;
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    if (n == 50) begin
      check(32'h0, 32'h1);
      results();
    end
  endtask

  task automatic wait_lvl(input logic [5:0] l, input logic [5:0] r);
    int n;
    for (n = 0; n < 8 && !(llev === l && rlev === r); n++)
      @(posedge clk);
    check({llev, rlev}, {l, r});
  endtask

  function automatic logic [31:0] port_of(input int j);
    case (j)
      2: return {dis, tie};
      3: return {mst, sena};
      4: return {wmode, mode};
      5: return lofs;
      default: return rofs;
    endcase
  endfunction

  // Write mode flag follows the upper mode bit inverted
  function automatic logic [31:0] port_exp(input int j, input logic [31:0] v);
    if (j == 4)
      return {~v[1], v[1:0]};
    return v & msk[j];
  endfunction

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, lx, rx} = 8'h0;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hf;
    miscompares = 0;
    samples_checked = 0;
    seed = $urandom(32'ha2c6);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({lsil, rsil, llev, rlev}, {2'b11, 6'h39, 6'h39});
    check({dis, tie, mst, sena, mode, wmode, lofs}, {7'h10, 3'h1, 8'h0});
    for (i = 0; i < 7; i++) begin
      rdreg(idx[i]);
      check(rd, rstv[i]);
    end
    $display("test reset values done");
    wr(8'h40, $urandom);
    check(rsp, `RESP_SLVERR);
    rdreg(8'h40);
    check(rd, 32'h0);
    check(rsp, `RESP_SLVERR);
    $display("test unmapped done");
    for (k = 0; k < 24; k++) begin
      i = (k < 4) ? 4 : 2 + k % 5;
      d = (k < 4) ? k : $urandom;
      wr(idx[i], d);
      rdreg(idx[i]);
      check(rd, d & msk[i]);
      check(port_of(i), port_exp(i, d));
    end
    $display("test servo fields done");
    wr(idx[0], 32'h005);
    repeat (4) @(posedge clk);
    check({lsil, llev}, {1'b0, 6'h39});
    rdreg(idx[0]);
    check(rd, 32'h005);
    wr(idx[1], 32'h0bf);
    wait_lvl(6'h05, 6'h3f);
    wr(idx[0], 32'h080);
    wait_lvl(6'h00, 6'h3f);
    $display("test level apply done");
    wr(idx[0], 32'h0d0);
    repeat (6) @(posedge clk);
    check(llev, 6'h00);
    lx <= 1'b1;
    @(posedge clk);
    lx <= 1'b0;
    wait_lvl(6'h10, 6'h3f);
    wr(idx[1], 32'h13f);
    check({lsil, rsil}, 2'b01);
    wr(idx[1], 32'h1c0);
    repeat (4) @(posedge clk);
    check(rlev, 6'h3f);
    rx <= 1'b1;
    @(posedge clk);
    rx <= 1'b0;
    wait_lvl(6'h10, 6'h00);
    $display("test crossing gate done");
    results();
  end
endmodule // spk_out_dc_servo_regs_tb_top
`default_nettype wire
